//--- core/msf_consts.vh
/*
 * Register map, field positions, reset values and bus response codes of
 * the metering status-flag block (upper half of the event status word).
 * Assumes it is included once per file, by its bare name, ahead of code.
 */
// Contract
// - Status bit 22 always reads as zero.
// - Status bit 23 sets when the current-channel peak period ends.
// - On that event the current peak result holds magnitude and phase.
// - Status bit 24 sets when the voltage-channel peak period ends.
// - On that event the voltage peak result holds magnitude and phase.
// - Status bit 25 sets when a new checksum differs from the run reference while run is on.
// - Status bits 31 to 26 always read as zero.
`ifndef MSF_CONSTS_VH
`define MSF_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define MSF_OFS_STATUS      8'h00
`define MSF_OFS_MASK        8'h04
`define MSF_OFS_CUR_PEAK    8'h08
`define MSF_OFS_VOLT_PEAK   8'h0c
`define MSF_OFS_RUN         8'h10
`define MSF_OFS_REF_SUM     8'h14
`define MSF_OFS_LAST_SUM    8'h18

// ----------------------------------------------------------------------
// status, mask and run field positions
// ----------------------------------------------------------------------
`define MSF_BIT_RSVD22      22
`define MSF_BIT_CUR_DONE    23
`define MSF_BIT_VOLT_DONE   24
`define MSF_BIT_SUM_ERR     25
`define MSF_RSVD_HI_MSB     31
`define MSF_RSVD_HI_LSB     26
`define MSF_BIT_RUN         0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MSF_RST_FLAG        1'b0
`define MSF_RST_MASK        3'h0
`define MSF_RST_RUN         1'b0
`define MSF_RST_WORD        32'h0000_0000
`define MSF_RSVD22_VAL      1'b0
`define MSF_RSVD_HI_VAL     6'h00

// ----------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------
`define MSF_RESP_OKAY       2'h0
`define MSF_RESP_SLVERR     2'h2

`endif

//--- core/msf_event_flag.v
/*
 * One sticky event flag: set by a hardware pulse, cleared by software.
 * Assumes set and clear come from logic on aclk; set wins over clear.
 */
`timescale 1ns/100ps
`default_nettype none
`include "msf_consts.vh"

module msf_event_flag (
    // clock and reset
    input  wire aclk,
    input  wire aresetn,
    // event and acknowledge
    input  wire set_evt,
    input  wire clr_req,
    // state
    output reg  flag_r
);

    reg flag_nxt;

    always @* begin
        flag_nxt = flag_r;
        if (set_evt) begin
            flag_nxt = 1'b1;
        end else if (clr_req) begin
            flag_nxt = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            flag_r <= `MSF_RST_FLAG;
        end else begin
            flag_r <= flag_nxt;
        end
    end

endmodule // msf_event_flag

`default_nettype wire

//--- core/msf_peak_capture.v
/*
 * Peak result holder: latches magnitude and phase when a peak period ends,
 * in the same edge that raises the matching status flag.
 * Assumes done, magnitude and phase come from logic on aclk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "msf_consts.vh"

module msf_peak_capture #(
    parameter MAG_W = 24,
    parameter PH_W  = 3
) (
    // clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    // peak datapath
    input  wire             done_evt,
    input  wire [MAG_W-1:0] peak_mag,
    input  wire [PH_W-1:0]  peak_phase,
    // held result: phase above magnitude, zero above that
    output reg  [31:0]      result_r
);

    localparam PAD_W = 32 - MAG_W - PH_W;

    always @(posedge aclk) begin
        if (!aresetn) begin
            result_r <= `MSF_RST_WORD;
        end else if (done_evt) begin
            result_r <= {{PAD_W{1'b0}}, peak_phase, peak_mag};
        end
    end

endmodule // msf_peak_capture

`default_nettype wire

//--- core/msf_status_upper.v
/*
 * Upper event status word of the metering core with its mask, peak
 * results, run control and checksum watch, behind an AXI4-Lite slave.
 * Assumes all datapath inputs are pulses and words on aclk; the lower
 * status bits and the peak and checksum engines live elsewhere.
 */
`timescale 1ns/100ps
`default_nettype none
`include "msf_consts.vh"

module msf_status_upper #(
    parameter MAG_W = 24,
    parameter PH_W  = 3,
    parameter SUM_W = 16
) (
    // clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    // axi4-lite write address
    input  wire [7:0]       s_axi_awaddr,
    input  wire [2:0]       s_axi_awprot,
    input  wire             s_axi_awvalid,
    output wire             s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]      s_axi_wdata,
    input  wire [3:0]       s_axi_wstrb,
    input  wire             s_axi_wvalid,
    output wire             s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]       s_axi_bresp,
    output reg              s_axi_bvalid,
    input  wire             s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]       s_axi_araddr,
    input  wire [2:0]       s_axi_arprot,
    input  wire             s_axi_arvalid,
    output wire             s_axi_arready,
    // axi4-lite read data
    output reg  [31:0]      s_axi_rdata,
    output reg  [1:0]       s_axi_rresp,
    output reg              s_axi_rvalid,
    input  wire             s_axi_rready,
    // current-channel peak datapath
    input  wire             current_peak_period_done,
    input  wire [MAG_W-1:0] current_peak_mag,
    input  wire [PH_W-1:0]  current_peak_phase,
    // voltage-channel peak datapath
    input  wire             voltage_peak_period_done,
    input  wire [MAG_W-1:0] voltage_peak_mag,
    input  wire [PH_W-1:0]  voltage_peak_phase,
    // configuration checksum engine
    input  wire             cfg_sum_valid,
    input  wire [SUM_W-1:0] cfg_sum,
    // control and interrupt
    output wire             run_en,
    output wire             irq
);

    // ------------------------------------------------------------------
    // address decode helpers
    // ------------------------------------------------------------------
    function mapped;
        input [7:0] addr;
        begin
            case (addr)
                `MSF_OFS_STATUS, `MSF_OFS_MASK,
                `MSF_OFS_CUR_PEAK, `MSF_OFS_VOLT_PEAK,
                `MSF_OFS_RUN, `MSF_OFS_REF_SUM,
                `MSF_OFS_LAST_SUM: mapped = 1'b1;
                default:           mapped = 1'b0;
            endcase
        end
    endfunction

    // byte-lane merge of write data over an old word
    function [31:0] lane_merge;
        input [31:0] old_w;
        input [31:0] new_w;
        input [3:0]  strb;
        integer      i;
        begin
            lane_merge = old_w;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    lane_merge[i*8 +: 8] = new_w[i*8 +: 8];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // write channel capture
    // ------------------------------------------------------------------
    reg         aw_held_r;
    reg  [7:0]  awaddr_r;
    reg         w_held_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    wire        wr_fire;
    wire        wr_hit;

    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
    assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_hit        = wr_fire && mapped(awaddr_r);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r  <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // write response
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `MSF_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_r) ? `MSF_RESP_OKAY : `MSF_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // register write strobes
    // ------------------------------------------------------------------
    wire [31:0] wr_word;
    wire        wr_status;
    wire        wr_mask;
    wire        wr_run;

    assign wr_word   = lane_merge(32'h0000_0000, wdata_r, wstrb_r);
    assign wr_status = wr_hit && (awaddr_r == `MSF_OFS_STATUS);
    assign wr_mask   = wr_hit && (awaddr_r == `MSF_OFS_MASK);
    assign wr_run    = wr_hit && (awaddr_r == `MSF_OFS_RUN);

    // ------------------------------------------------------------------
    // run control and checksum watch
    // ------------------------------------------------------------------
    reg             run_r;
    reg             run_nxt;
    reg [SUM_W-1:0] ref_sum_r;
    reg [SUM_W-1:0] last_sum_r;
    wire            run_rise;
    wire            sum_err_evt;

    // reference taken at the write that turns run from zero to one
    assign run_rise    = wr_run && wstrb_r[0] && wdata_r[`MSF_BIT_RUN] && !run_r;
    assign sum_err_evt = cfg_sum_valid && run_r && (cfg_sum != ref_sum_r);
    assign run_en      = run_r;

    always @* begin
        run_nxt = run_r;
        if (wr_run && wstrb_r[0]) begin
            run_nxt = wdata_r[`MSF_BIT_RUN];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            run_r     <= `MSF_RST_RUN;
            ref_sum_r <= {SUM_W{1'b0}};
        end else begin
            run_r <= run_nxt;
            if (run_rise) begin
                ref_sum_r <= cfg_sum;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            last_sum_r <= {SUM_W{1'b0}};
        end else if (cfg_sum_valid) begin
            last_sum_r <= cfg_sum;
        end
    end

    // ------------------------------------------------------------------
    // peak results
    // ------------------------------------------------------------------
    wire [31:0] cur_peak_word;
    wire [31:0] volt_peak_word;

    // result and flag update on the same edge                          
    msf_peak_capture #(
        .MAG_W (MAG_W),
        .PH_W  (PH_W)
    ) u_cur_peak (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .done_evt   (current_peak_period_done),
        .peak_mag   (current_peak_mag),
        .peak_phase (current_peak_phase),
        .result_r   (cur_peak_word)
    );

    msf_peak_capture #(
        .MAG_W (MAG_W),
        .PH_W  (PH_W)
    ) u_volt_peak (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .done_evt   (voltage_peak_period_done),
        .peak_mag   (voltage_peak_mag),
        .peak_phase (voltage_peak_phase),
        .result_r   (volt_peak_word)
    );

    // ------------------------------------------------------------------
    // sticky event flags, write one to clear
    // ------------------------------------------------------------------
    wire cur_done_flag;
    wire volt_done_flag;
    wire sum_err_flag;

    msf_event_flag u_cur_flag (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set_evt (current_peak_period_done),
        .clr_req (wr_status && wr_word[`MSF_BIT_CUR_DONE]),
        .flag_r  (cur_done_flag)
    );

    msf_event_flag u_volt_flag (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set_evt (voltage_peak_period_done),
        .clr_req (wr_status && wr_word[`MSF_BIT_VOLT_DONE]),
        .flag_r  (volt_done_flag)
    );

    msf_event_flag u_sum_flag (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set_evt (sum_err_evt),
        .clr_req (wr_status && wr_word[`MSF_BIT_SUM_ERR]),
        .flag_r  (sum_err_flag)
    );

    // ------------------------------------------------------------------
    // status word and mask
    // ------------------------------------------------------------------
    reg  [31:0] status_word;
    reg  [2:0]  mask_r;
    reg  [2:0]  mask_nxt;
    wire [31:0] mask_word;
    reg         irq_r;

    always @* begin
        status_word = 32'h0000_0000;
        status_word[`MSF_BIT_RSVD22] = `MSF_RSVD22_VAL;
        status_word[`MSF_BIT_CUR_DONE] = cur_done_flag;
        status_word[`MSF_BIT_VOLT_DONE] = volt_done_flag;
        status_word[`MSF_BIT_SUM_ERR] = sum_err_flag;
        status_word[`MSF_RSVD_HI_MSB:`MSF_RSVD_HI_LSB] = `MSF_RSVD_HI_VAL;
    end

    // mask lanes follow the status layout: bit 23 in lane 2, bits 24..25 in lane 3
    always @* begin
        mask_nxt = mask_r;
        if (wr_mask && wstrb_r[2]) begin
            mask_nxt[0] = wdata_r[`MSF_BIT_CUR_DONE];
        end
        if (wr_mask && wstrb_r[3]) begin
            mask_nxt[2:1] = wdata_r[`MSF_BIT_SUM_ERR:`MSF_BIT_VOLT_DONE];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            mask_r <= `MSF_RST_MASK;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    assign mask_word = {6'h00, mask_r, 23'h000000};

    // interrupt level from a flip-flop, one cycle behind flags and mask
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_word & mask_word);
        end
    end

    assign irq = irq_r;

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    reg [31:0] rd_word;

    assign s_axi_arready = !s_axi_rvalid;

    always @* begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            `MSF_OFS_STATUS:    rd_word = status_word;
            `MSF_OFS_MASK:      rd_word = mask_word;
            `MSF_OFS_CUR_PEAK:  rd_word = cur_peak_word;
            `MSF_OFS_VOLT_PEAK: rd_word = volt_peak_word;
            `MSF_OFS_RUN:       rd_word = {31'h0000_0000, run_r};
            `MSF_OFS_REF_SUM:   rd_word = {{(32-SUM_W){1'b0}}, ref_sum_r};
            `MSF_OFS_LAST_SUM:  rd_word = {{(32-SUM_W){1'b0}}, last_sum_r};
            default:            rd_word = 32'h0000_0000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `MSF_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= mapped(s_axi_araddr) ? `MSF_RESP_OKAY : `MSF_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // msf_status_upper

`default_nettype wire

//--- bench/msf_status_upper_chk.sv
/*
 * Checker for the upper event status word: bus answers and status
 * read-back against a small model of the two peak flags.
 * Assumes it is bound to msf_status_upper and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none
module msf_status_upper_chk (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    // peak events
    input wire logic        current_peak_period_done,
    input wire logic        voltage_peak_period_done
);
    // ----------------------------------------------------------------
    // write capture and flag model
    // ----------------------------------------------------------------
    logic        aw_h_r, w_h_r;
    logic [7:0]  wa_r, ra_r;
    logic [31:0] wd_r;
    logic [3:0]  ws_r;
    logic [1:0]  fl_r, rf_r;
    wire         commit = aw_h_r && w_h_r;
    wire         clr_st = commit && (wa_r == 8'h00);
    wire         rd_st  = s_axi_rvalid && (ra_r == 8'h00);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_h_r <= 1'b0;
            w_h_r  <= 1'b0;
            fl_r   <= 2'h0;
        end else begin
            aw_h_r  <= (aw_h_r && !commit) || (s_axi_awvalid && s_axi_awready);
            w_h_r   <= (w_h_r && !commit) || (s_axi_wvalid && s_axi_wready);
            fl_r[0] <= current_peak_period_done || (fl_r[0] && !(clr_st && wd_r[23] && ws_r[2]));
            fl_r[1] <= voltage_peak_period_done || (fl_r[1] && !(clr_st && wd_r[24] && ws_r[3]));
        end
        if (s_axi_awvalid && s_axi_awready)
            wa_r <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) begin
            wd_r <= s_axi_wdata;
            ws_r <= s_axi_wstrb;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            ra_r <= s_axi_araddr;
            rf_r <= fl_r;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_rsvd22_zero: assert property (rd_st |-> !s_axi_rdata[22])
        else $error("status bit 22 read as one");
    a_rsvd_hi_zero: assert property (rd_st |-> s_axi_rdata[31:26] == 6'h00)
        else $error("status bits 31..26 not zero");
    a_cur_flag_read: assert property (rd_st |-> s_axi_rdata[23] == rf_r[0])
        else $error("current peak flag read wrong");
    a_volt_flag_read: assert property (rd_st |-> s_axi_rdata[24] == rf_r[1])
        else $error("voltage peak flag read wrong");
    a_write_answer: assert property (commit |=> s_axi_bvalid)
        else $error("write response late");
    a_b_no_early: assert property (!commit && !s_axi_bvalid |=> !s_axi_bvalid)
        else $error("write response without write");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
endmodule // msf_status_upper_chk
`default_nettype wire

//--- bench/test_msf_status_upper.sv
/*
 * Bench for msf_status_upper: bus accesses with expected values,
 * peak and checksum events driven at the ports.
 * Assumes default parameters and a 40 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
module test_msf_status_upper;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        aclk, aresetn, run_en, irq, cfg_sum_valid;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic        current_peak_period_done, voltage_peak_period_done;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [23:0] current_peak_mag, voltage_peak_mag;
    logic [2:0]  current_peak_phase, voltage_peak_phase;
    logic [15:0] cfg_sum;
    int          n_errors, cmp_count, cyc;

    msf_status_upper msf_status_upper_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .current_peak_period_done, .current_peak_mag, .current_peak_phase,
        .voltage_peak_period_done, .voltage_peak_mag, .voltage_peak_phase,
        .cfg_sum_valid, .cfg_sum, .run_en, .irq
    );

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(n, e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // one-cycle event pulses; both channels see the same magnitude and phase
    task automatic ev(input logic c, input logic v, input logic s, input logic [23:0] m,
                      input logic [2:0] p, input logic [15:0] k);
        current_peak_period_done <= c;
        voltage_peak_period_done <= v;
        cfg_sum_valid            <= s;
        current_peak_mag         <= m;
        current_peak_phase       <= p;
        voltage_peak_mag         <= m;
        voltage_peak_phase       <= p;
        cfg_sum                  <= k;
        @(posedge aclk);
        {current_peak_period_done, voltage_peak_period_done, cfg_sum_valid} <= 3'h0;
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, current_peak_period_done, voltage_peak_period_done, cfg_sum_valid} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, cfg_sum} = '0;
        {current_peak_mag, voltage_peak_mag, current_peak_phase, voltage_peak_phase} = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("irq", 32'h0, {31'h0, irq});
        rd("status", 8'h00, 32'h0, 2'h0);
        rd("mask", 8'h04, 32'h0, 2'h0);
        rd("run", 8'h10, 32'h0, 2'h0);
        ev(1'b1, 1'b0, 1'b0, 24'habcdef, 3'h5, 16'h0);
        rd("status", 8'h00, 32'h0080_0000, 2'h0);
        rd("cur_peak", 8'h08, 32'h05ab_cdef, 2'h0);
        wr(8'h00, 32'h0080_0000, 4'h8, 2'h0);
        rd("status", 8'h00, 32'h0080_0000, 2'h0);
        wr(8'h00, 32'h0080_0000, 4'h4, 2'h0);
        rd("status", 8'h00, 32'h0, 2'h0);
        ev(1'b0, 1'b1, 1'b0, 24'hffffff, 3'h7, 16'h0);
        rd("status", 8'h00, 32'h0100_0000, 2'h0);
        rd("volt_peak", 8'h0c, 32'h07ff_ffff, 2'h0);
        ev(1'b1, 1'b0, 1'b0, 24'h000001, 3'h0, 16'h0);
        rd("status", 8'h00, 32'h0180_0000, 2'h0);
        rd("cur_peak", 8'h08, 32'h0000_0001, 2'h0);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'h04, 32'hffff_ffff, 4'hf, 2'h0);
        rd("mask", 8'h04, 32'h0380_0000, 2'h0);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'h00, 32'hffff_ffff, 4'hf, 2'h0);
        rd("status", 8'h00, 32'h0, 2'h0);
        chk("irq", 32'h0, {31'h0, irq});
        ev(1'b0, 1'b0, 1'b1, 24'h0, 3'h0, 16'h4321);
        rd("status", 8'h00, 32'h0, 2'h0);
        wr(8'h10, 32'h0000_0001, 4'h1, 2'h0);
        chk("run_en", 32'h1, {31'h0, run_en});
        rd("ref_sum", 8'h14, 32'h0000_4321, 2'h0);
        ev(1'b0, 1'b0, 1'b1, 24'h0, 3'h0, 16'h4321);
        rd("status", 8'h00, 32'h0, 2'h0);
        ev(1'b0, 1'b0, 1'b1, 24'h0, 3'h0, 16'h4322);
        rd("status", 8'h00, 32'h0200_0000, 2'h0);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'h10, 32'h0, 4'hf, 2'h0);
        chk("run_en", 32'h0, {31'h0, run_en});
        wr(8'h20, 32'hffff_ffff, 4'hf, 2'h2);
        rd("unmapped", 8'h20, 32'h0, 2'h2);
        wr(8'h08, 32'hffff_ffff, 4'hf, 2'h0);
        rd("cur_peak", 8'h08, 32'h0000_0001, 2'h0);
        summarize();
    end
endmodule // test_msf_status_upper

bind msf_status_upper msf_status_upper_chk msf_status_upper_chk_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .current_peak_period_done, .voltage_peak_period_done
);
`default_nettype wire
